// ==== common/sonet_txbus_pkg.sv ====
/*
  constants, register layout and carriers for the transmit parallel byte bus.
  assumes a 50 MHz system clock from which the 19.44 MHz bus clock is synthesised.
*/
package sonet_txbus_pkg;

  // register offsets on the byte-wide processor port
  localparam logic [15:0] TX_BUS_CTRL_ADDR = 16'h0137;
  localparam logic [15:0] TX_BUS_STAT_ADDR = 16'h0138;
  localparam logic [7:0] TX_BUS_CTRL_RESET = 8'h00;
  localparam logic [7:0] TX_BUS_STAT_RESET = 8'h00;

  // clock synthesis figures
  localparam longint unsigned SYS_CLK_HZ = 64'd50_000_000;
  localparam longint unsigned BUS_CLK_HZ = 64'd19_440_000;
  localparam int NCO_W = 24;
  localparam logic [NCO_W-1:0] NCO_INC = NCO_W'((BUS_CLK_HZ << NCO_W) / SYS_CLK_HZ);

  // buffer depth in front of the bus
  localparam int FIFO_DEPTH = 16;

  // device operating modes
  typedef enum logic [1:0] {
    MODE_SONET = 2'h0,
    MODE_ATM_UNI = 2'h1,
    MODE_PPP_STS3C = 2'h2
  } op_mode_e;

  // control register layout, msb first
  typedef struct packed {
    logic [1:0] spare;
    logic aps_role_req;
    logic bus_select;
    logic no_realign_mode;
    logic bus_enable;
    logic parity_cover_flags;
    logic parity_odd;
  } ctrl_s;

  // status register layout, msb first
  typedef struct packed {
    logic [1:0] spare;
    logic ais_pin_level;
    logic clock_pin_level;
    logic aps_role_active;
    logic underrun_seen;
    logic fifo_full;
    logic fifo_empty;
  } stat_s;

  // one byte slot of the outgoing stream with its qualifiers
  typedef struct packed {
    logic [7:0] data;
    logic payload;
    logic marker;
    logic ais;
  } bus_word_s;

endpackage : sonet_txbus_pkg

// ==== rtl/sonet_tx_parallel_bus_out.sv ====
/*
  transmit parallel byte bus output: a stream buffer and the bus launcher.
  assumes a byte stream from framing logic on clk_sys_i, a byte-wide register
  port on the same clock, and a far end that samples on the falling bus edge.
*/
`timescale 1ns/1ps

module sonet_txbus_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // levels
  output logic full_o,
  output logic empty_o
);

  localparam int AW = $clog2(DEPTH);

  // refuse depths the pointer arithmetic cannot wrap cleanly
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  // extra pointer bit tells full from empty
  assign empty_o = (wr_ptr_q == rd_ptr_q);
  assign full_o = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  assign in_ready_o = !full_o;
  assign out_valid_o = !empty_o;
  assign push = in_valid_i && !full_o;
  assign pop = out_ready_i && !empty_o;
  assign out_data_o = mem_q[rd_ptr_q[AW-1:0]];

  // storage is written only, never reset, to keep it plain flip-flops
  always_ff @(posedge clk_sys_i)
  begin
    if (push)
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
  end

  // write pointer
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      wr_ptr_q <= '0;
    else if (push)
      wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
  end

  // read pointer
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      rd_ptr_q <= '0;
    else if (pop)
      rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
  end

endmodule : sonet_txbus_fifo

module sonet_tx_parallel_bus_out #(
  parameter int DEPTH = sonet_txbus_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // device operating mode
  input wire sonet_txbus_pkg::op_mode_e op_mode_i,
  // byte stream from framing logic
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire sonet_txbus_pkg::bus_word_s in_word_i,
  // register port
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  output logic cpu_ack_o,
  // bus clock pin, two-way
  input wire logic tx_bus_clock_i,
  output logic tx_bus_clock_o,
  output logic tx_bus_clock_oe_o,
  // alarm pin, two-way
  input wire logic tx_bus_ais_flag_i,
  output logic tx_bus_ais_flag_o,
  output logic tx_bus_ais_flag_oe_o,
  // bus outputs
  output logic [7:0] tx_bus_data_byte_o,
  output logic tx_bus_payload_flag_o,
  output logic tx_bus_phase_marker_o,
  output logic tx_bus_parity_out_o
);

  import sonet_txbus_pkg::*;

  localparam int WORD_W = $bits(bus_word_s);

  ctrl_s ctrl_q;
  stat_s stat_now;
  logic underrun_q;
  logic [NCO_W-1:0] nco_q;
  logic bus_clk_q;
  logic bus_rise;
  logic aps_role;
  logic launch;
  logic fifo_valid;
  logic fifo_full;
  logic fifo_empty;
  logic [WORD_W-1:0] fifo_data;
  bus_word_s head_word;
  bus_word_s next_word;
  logic [7:0] data_q;
  logic payload_q;
  logic marker_q;
  logic ais_q;
  logic parity_q;
  logic [1:0] clk_pin_sync_q;
  logic [1:0] ais_pin_sync_q;
  logic [7:0] rdata_q;
  logic ack_q;

  // parity over the byte, optionally with payload flag and marker
  function automatic logic parity_calc(input bus_word_s w, input ctrl_s c);
    logic p;
    p = ^w.data;
    if (c.parity_cover_flags)
    begin
      p = p ^ w.payload ^ w.marker;
    end
    if (c.parity_odd)
    begin
      p = !p;
    end
    return p;
  endfunction : parity_calc

  // stream buffer; it drains one byte per bus clock, so the source stalls
  sonet_txbus_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o),
    .in_data_i(in_word_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(launch),
    .out_data_o(fifo_data),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  assign head_word = bus_word_s'(fifo_data);

  // phase accumulator; high time jitters by one system cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      nco_q <= '0;
    else
      nco_q <= nco_q + NCO_INC;
  end

  // bus clock follows the accumulator msb, one cycle late
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      bus_clk_q <= 1'b0;
    else
      bus_clk_q <= nco_q[NCO_W-1];
  end

  // outputs load in the same cycle the clock pin goes high
  assign bus_rise = nco_q[NCO_W-1] && !bus_clk_q;

  // aps roles only in atm or ppp mode
  assign aps_role = ctrl_q.aps_role_req && (op_mode_i == MODE_ATM_UNI || op_mode_i == MODE_PPP_STS3C);

  assign launch = bus_rise && ctrl_q.bus_enable && !aps_role;

  // idle slot when the buffer runs dry: overhead flag, no marks
  always_comb
  begin
    next_word = '0;
    if (fifo_valid)
    begin
      next_word = head_word;
    end
    next_word.marker = next_word.marker && ctrl_q.no_realign_mode;
    next_word.ais = next_word.ais && ctrl_q.no_realign_mode;
  end

  // byte and payload flag launched together
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      data_q <= 8'h00;
      payload_q <= 1'b0;
    end
    else if (bus_rise)
    begin
      data_q <= launch ? next_word.data : 8'h00;
      payload_q <= launch && next_word.payload;
    end
  end

  // one slot per byte keeps the marker to one period
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      marker_q <= 1'b0;
    else if (bus_rise)
      // marker paired with the byte it marks
      marker_q <= launch && next_word.marker;
  end

  // alarm coincident with each byte of an alarmed path
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      ais_q <= 1'b0;
    else if (bus_rise)
      ais_q <= launch && next_word.ais;
  end

  // parity, held low unless this bus carries the data
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      parity_q <= 1'b0;
    else if (bus_rise)
      parity_q <= launch && ctrl_q.bus_select && parity_calc(next_word, ctrl_q);
  end

  // pin drivers; in aps role the two-way pins are released
  assign tx_bus_clock_o = bus_clk_q;
  assign tx_bus_clock_oe_o = !aps_role;
  assign tx_bus_ais_flag_o = ais_q;
  assign tx_bus_ais_flag_oe_o = !aps_role;
  assign tx_bus_data_byte_o = data_q;
  assign tx_bus_payload_flag_o = payload_q;
  assign tx_bus_phase_marker_o = marker_q;
  assign tx_bus_parity_out_o = parity_q;

  // pin levels pass two flops before the status register sees them
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      clk_pin_sync_q <= 2'b00;
      ais_pin_sync_q <= 2'b00;
    end
    else
    begin
      clk_pin_sync_q <= {clk_pin_sync_q[0], tx_bus_clock_i};
      ais_pin_sync_q <= {ais_pin_sync_q[0], tx_bus_ais_flag_i};
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      ctrl_q <= ctrl_s'(TX_BUS_CTRL_RESET);
    else if (cpu_wr_i && cpu_addr_i == TX_BUS_CTRL_ADDR)
      ctrl_q <= ctrl_s'(cpu_wdata_i);
  end

  // underrun is sticky; a new underrun wins over a write-one clear
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      underrun_q <= 1'b0;
    else if (launch && !fifo_valid)
      underrun_q <= 1'b1;
    else if (cpu_wr_i && cpu_addr_i == TX_BUS_STAT_ADDR && cpu_wdata_i[2])
      underrun_q <= 1'b0;
  end

  // live status view
  always_comb
  begin
    stat_now = stat_s'(TX_BUS_STAT_RESET);
    stat_now.fifo_empty = fifo_empty;
    stat_now.fifo_full = fifo_full;
    stat_now.underrun_seen = underrun_q;
    stat_now.aps_role_active = aps_role;
    stat_now.clock_pin_level = clk_pin_sync_q[1];
    stat_now.ais_pin_level = ais_pin_sync_q[1];
  end

  // read data registered; unmapped offsets read zero
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= cpu_wr_i || cpu_rd_i;
      if (cpu_rd_i)
      begin
        unique case (cpu_addr_i)
          TX_BUS_CTRL_ADDR: rdata_q <= ctrl_q;
          TX_BUS_STAT_ADDR: rdata_q <= stat_now;
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign cpu_rdata_o = rdata_q;
  assign cpu_ack_o = ack_q;

endmodule : sonet_tx_parallel_bus_out

// ==== testbench/bus_sink.sv ====
/* far-end capture logic of the byte bus.
   assumes the bus clock pin level at its input. */
`timescale 1ns/1ps
module bus_sink (
  // bus pins
  input wire logic clk_pin_i,
  input wire logic [11:0] bus_i,
  // captured slot, toggle per capture
  output logic [11:0] cap_o,
  output logic got_o
);
  initial got_o = '0;
  // falling edge capture
  // sample on the falling edge, half a period clear of the launch
  always @(negedge clk_pin_i)
  begin
    cap_o <= bus_i;
    got_o <= ~got_o;
  end
endmodule : bus_sink

// ==== testbench/sonet_txbus_out_props.sv ====
/* port checks for the byte bus block.
   assumes control is mirrored from writes at 0x0137. */
`timescale 1ns/1ps
module sonet_txbus_out_props
  import sonet_txbus_pkg::*;
(
  // clock, reset, mode
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire sonet_txbus_pkg::op_mode_e op_mode_i,
  // register port
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_ack_o,
  // bus pins
  input wire logic tx_bus_clock_o,
  input wire logic tx_bus_clock_oe_o,
  input wire logic tx_bus_ais_flag_o,
  input wire logic tx_bus_ais_flag_oe_o,
  input wire logic [7:0] tx_bus_data_byte_o,
  input wire logic tx_bus_payload_flag_o,
  input wire logic tx_bus_phase_marker_o,
  input wire logic tx_bus_parity_out_o
);
  ctrl_s ctrl_q;
  logic aps_now;
  logic rise;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // mirror of control; gates are judged only while it is steady
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      ctrl_q <= TX_BUS_CTRL_RESET;
    else if (cpu_wr_i && cpu_addr_i == TX_BUS_CTRL_ADDR)
      ctrl_q <= cpu_wdata_i;
  end
  // role and rise markers
  assign aps_now = ctrl_q.aps_role_req && op_mode_i != MODE_SONET;
  assign rise = tx_bus_clock_o && tx_bus_clock_oe_o;
  sequence s_next_rise;
    ##1 !$rose(tx_bus_clock_o) ##[1:2] ($rose(tx_bus_clock_o) || !tx_bus_clock_oe_o);
  endsequence
  a_out_hold: assert property (
    !$rose(tx_bus_clock_o) |-> $stable({tx_bus_data_byte_o, tx_bus_payload_flag_o,
    tx_bus_phase_marker_o, tx_bus_ais_flag_o, tx_bus_parity_out_o})) else $error("output moved off a rise");
  a_clock_period: assert property (
    $rose(tx_bus_clock_o) && tx_bus_clock_oe_o |-> s_next_rise) else $error("bus clock period");
  a_flag_gate: assert property (
    $rose(rise) && $stable(ctrl_q) && !(ctrl_q.bus_enable && ctrl_q.no_realign_mode)
    |-> !tx_bus_phase_marker_o && !tx_bus_ais_flag_o) else $error("marker or alarm not gated");
  a_parity_gate: assert property (
    $rose(rise) && $stable(ctrl_q) && !ctrl_q.bus_select |-> !tx_bus_parity_out_o) else $error("parity not gated");
  a_parity_value: assert property (
    $rose(rise) && $stable(ctrl_q) && ctrl_q.bus_select && tx_bus_data_byte_o != 8'h00
    |-> tx_bus_parity_out_o == (^tx_bus_data_byte_o ^ ctrl_q.parity_odd ^ (ctrl_q.parity_cover_flags
    & (tx_bus_payload_flag_o ^ tx_bus_phase_marker_o)))) else $error("parity value");
  a_aps_release: assert property (
    aps_now |-> !tx_bus_clock_oe_o && !tx_bus_ais_flag_oe_o) else $error("pins kept in aps role");
  a_pins_driven: assert property (
    !aps_now |-> tx_bus_clock_oe_o && tx_bus_ais_flag_oe_o) else $error("pins released");
  a_ack_pulse: assert property (
    cpu_wr_i || cpu_rd_i |=> cpu_ack_o) else $error("no register ack");
endmodule : sonet_txbus_out_props

bind sonet_tx_parallel_bus_out sonet_txbus_out_props i_props (.*);

// ==== testbench/testbench.sv ====
/* self-checking bench of the byte bus block.
   assumes the far side is bus_sink on the pins. */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module testbench;
  import sonet_txbus_pkg::*;
  logic clk_sys_i = '0;
  logic rst_i = '1;
  op_mode_e op_mode_i = MODE_SONET;
  logic in_valid_i = '0;
  logic in_ready_o;
  bus_word_s in_word_i = '0;
  logic [15:0] cpu_addr_i = '0;
  logic cpu_wr_i = '0;
  logic cpu_rd_i = '0;
  logic [7:0] cpu_wdata_i = '0;
  logic [7:0] cpu_rdata_o, tx_bus_data_byte_o;
  logic cpu_ack_o, tx_bus_clock_i, tx_bus_clock_o, tx_bus_clock_oe_o;
  logic tx_bus_ais_flag_i, tx_bus_ais_flag_o, tx_bus_ais_flag_oe_o;
  logic tx_bus_payload_flag_o, tx_bus_phase_marker_o, tx_bus_parity_out_o;
  logic aps_clk = '0;
  logic aps_run = '0;
  logic got;
  logic [11:0] cap, e;
  logic m;
  ctrl_s ctl = '0;
  bus_word_s w;
  bus_word_s exp_q[$];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] cfg_tab[6] = '{8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h14, 8'h0C};
  sonet_tx_parallel_bus_out i_sonet_tx_parallel_bus_out (.*);
  bus_sink i_bus_sink (
    .clk_pin_i(tx_bus_clock_i),
    .bus_i({tx_bus_data_byte_o, tx_bus_payload_flag_o, tx_bus_phase_marker_o, tx_bus_ais_flag_i, tx_bus_parity_out_o}),
    .cap_o(cap),
    .got_o(got)
  );
  // pin levels; the far side clocks the pins only in aps role
  assign tx_bus_clock_i = tx_bus_clock_oe_o ? tx_bus_clock_o : aps_clk;
  assign tx_bus_ais_flag_i = tx_bus_ais_flag_oe_o ? tx_bus_ais_flag_o : ~aps_clk;
  always #10 clk_sys_i = ~clk_sys_i;
  always #80 aps_clk = aps_run ? ~aps_clk : aps_clk;
  // hang guard
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_errors++;
      end_sim();
    end
  end
  // model: idle slots carry a zero byte, our bytes never do
  always @(got)
  begin
    if (cap[11:4] != 8'h00)
    begin
      w = exp_q.size() != 0 ? exp_q.pop_front() : '0;
      m = w.marker & ctl.no_realign_mode;
      e = {w.data, w.payload, m, w.ais & ctl.no_realign_mode,
        ctl.bus_select & (^w.data ^ ctl.parity_odd ^ (ctl.parity_cover_flags & (w.payload ^ m)))};
      `CHK(cap, e)
    end
  end
  task automatic cpu(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    cpu_wr_i <= wr;
    cpu_rd_i <= ~wr;
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    @(posedge clk_sys_i);
    cpu_wr_i <= '0;
    cpu_rd_i <= '0;
    #1;
    `CHK(cpu_ack_o, 1'b1)
  endtask : cpu
  task automatic push(input bus_word_s pw);
    in_word_i <= pw;
    in_valid_i <= '1;
    do @(posedge clk_sys_i);
    while (in_ready_o !== 1'b1);
    exp_q.push_back(pw);
  endtask : push
  // fill while stopped, then let the bus drain it
  task automatic run(input logic [7:0] c);
    cpu(1'b1, TX_BUS_CTRL_ADDR, c & 8'hFB);
    ctl = c;
    // stopped bus: clearing the sticky underrun holds
    cpu(1'b1, TX_BUS_STAT_ADDR, 8'h04);
    cpu(1'b0, TX_BUS_STAT_ADDR, 8'h00);
    `CHK(cpu_rdata_o & 8'h0F, 8'h01)
    @(posedge clk_sys_i);
    // one marked byte per fill keeps the marker to one period
    for (int k = 0; k < FIFO_DEPTH; k++)
      push({8'($urandom) | 8'h01, 1'($urandom), k == 5, 1'($urandom)});
    in_valid_i <= '0;
    #1;
    `CHK(in_ready_o, 1'b0)
    cpu(1'b1, TX_BUS_CTRL_ADDR, c);
    cpu(1'b0, TX_BUS_CTRL_ADDR, 8'h00);
    `CHK(cpu_rdata_o, c)
    repeat (150) if (exp_q.size() != 0) @(posedge clk_sys_i);
    `CHK(exp_q.size(), 0)
    // a running bus with a dry buffer flags the underrun
    cpu(1'b0, TX_BUS_STAT_ADDR, 8'h00);
    `CHK(cpu_rdata_o & 8'h0F, 8'h05)
  endtask : run
  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    void'($urandom(32'h21e6));
    repeat (10) @(posedge clk_sys_i);
    rst_i <= '0;
    // a write to an unmapped offset is ignored, then control reads its reset value
    cpu(1'b1, 16'h0200, 8'hFF);
    cpu(1'b0, 16'h0200, 8'h00);
    `CHK(cpu_rdata_o, 8'h00)
    cpu(1'b0, TX_BUS_CTRL_ADDR, 8'h00);
    `CHK(cpu_rdata_o, TX_BUS_CTRL_RESET)
    foreach (cfg_tab[i]) run(cfg_tab[i]);
    // aps role takes the pins only in the atm and ppp modes
    aps_run = '1;
    cpu(1'b1, TX_BUS_CTRL_ADDR, 8'h3C);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_sys_i);
      op_mode_i <= op_mode_e'(k);
      #1;
      `CHK({tx_bus_clock_oe_o, tx_bus_ais_flag_oe_o}, {2{k == 0}})
    end
    cpu(1'b0, TX_BUS_STAT_ADDR, 8'h00);
    `CHK(cpu_rdata_o & 8'h08, 8'h08)
    end_sim();
  end
endmodule : testbench
